// [src/ptlb_logic_group.sv]
// logic block group with routing array, i/o control and apb configuration
//
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/100ps
`include "ptlb_regs.svh"
module ptlb_logic_group (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic [11:0]           paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic [31:0]                prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  global_clock_pin_one,
  input  wire logic                  global_clock_pin_two,
  input  wire logic                  global_clear_pin_low,
  input  wire logic                  oe_pin_one,
  input  wire logic                  oe_pin_two,
  input  wire logic [`PTLB_N_MC-1:0] io_in,
  output logic [`PTLB_N_MC-1:0]      io_out,
  output logic [`PTLB_N_MC-1:0]      io_oe
);
  //--------------------------------------------------------------------
  // decoding helpers
  //--------------------------------------------------------------------
  // register region of an address
  function automatic ptlb_pkg::ptlb_rg_t ptlb_region(input logic [11:0] a);
    ptlb_region = ptlb_pkg::PTLB_RG_NONE;
    if (a[1:0] != 2'h0)
      ptlb_region = ptlb_pkg::PTLB_RG_NONE;
    else if (a == `PTLB_A_CTRL)
      ptlb_region = ptlb_pkg::PTLB_RG_CTRL;
    else if (a == `PTLB_A_STAT)
      ptlb_region = ptlb_pkg::PTLB_RG_STAT;
    else if (a == `PTLB_A_CLK)
      ptlb_region = ptlb_pkg::PTLB_RG_CLK;
    else if (a >= `PTLB_A_OE && a < `PTLB_A_OE + 12'(4 * `PTLB_N_OE))
      ptlb_region = ptlb_pkg::PTLB_RG_OE;
    else if (a >= `PTLB_A_MC && a < `PTLB_A_MC + 12'(4 * `PTLB_N_MC))
      ptlb_region = ptlb_pkg::PTLB_RG_MC;
    else if (a >= `PTLB_A_RT && a < `PTLB_A_RT + 12'(4 * `PTLB_N_GIN))
      ptlb_region = ptlb_pkg::PTLB_RG_RT;
    else if (a >= `PTLB_A_TM && a < `PTLB_A_TM + 12'(4 * `PTLB_N_TW))
      ptlb_region = ptlb_pkg::PTLB_RG_TM;
  endfunction : ptlb_region

  // word index inside a region
  function automatic logic [8:0] ptlb_index(input logic [11:0] a, input logic [11:0] base);
    logic [11:0] off;
    off = a - base;
    ptlb_index = off[10:2];
  endfunction : ptlb_index

  // one source picked by a stored index, zero when out of range
  function automatic logic ptlb_pick(input logic [`PTLB_N_SRC-1:0] src, input logic [5:0] idx);
    ptlb_pick = (idx < 6'(`PTLB_N_SRC)) ? src[idx] : 1'b0;
  endfunction : ptlb_pick

  //--------------------------------------------------------------------
  // state and fabric wiring
  //--------------------------------------------------------------------
  ptlb_pkg::ptlb_top_st_t s, n;
  ptlb_pkg::ptlb_rg_t     rg;
  logic [31:0]            rdata;
  logic [8:0]             idx;
  logic [3:0]             oes;
  logic [`PTLB_N_SRC-1:0] src;
  logic [`PTLB_N_SRC-1:0] oesrc;
  logic [`PTLB_N_GIN-1:0] gin;
  logic [`PTLB_N_OE-1:0]  oenet;
  logic [1:0]             gnet;
  logic [`PTLB_N_LIT-1:0] lit;
  logic [`PTLB_N_MC-1:0]  q, shr, lend, bor;
  logic [`PTLB_N_MC-1:0][`PTLB_MAXSET-1:0]                    bset;
  logic [`PTLB_N_MC-1:0][`PTLB_N_PT-1:0][`PTLB_N_LIT-1:0]     tmask, cmask;

  // routing sources: macrocell feedback, pins, dedicated inputs
  assign src = {s.fb, io_in, oe_pin_two, oe_pin_one, global_clear_pin_low,
                global_clock_pin_two, global_clock_pin_one};
  // global enable sources: cells, pins, true and complement enable inputs
  assign oesrc = {1'b0, s.fb, io_in, ~oe_pin_two, oe_pin_two,
                  ~oe_pin_one, oe_pin_one};
  // inverted shareable terms registered to keep the array loop-free
  assign lit = {s.shr, gin};

  // global clock networks
  assign gnet[0] = (s.clk[0] ? global_clock_pin_two : global_clock_pin_one) ^ s.clk[1];
  assign gnet[1] = (s.clk[2] ? global_clock_pin_two : global_clock_pin_one) ^ s.clk[3];

  genvar g, k;
  generate
    // group inputs: and gate of a source with its stored enable
    for (g = 0; g < `PTLB_N_GIN; g++)
    begin : g_rt
      assign gin[g] = s.rt[g][`PTLB_RT_EN] & ptlb_pick(src, s.rt[g][5:0]);
    end
    // global output enables
    for (g = 0; g < `PTLB_N_OE; g++)
    begin : g_oe
      assign oenet[g] = ptlb_pick(oesrc, s.oe[g]);
    end
    // sixteen macrocells with masks and downward borrowing
    for (g = 0; g < `PTLB_N_MC; g++)
    begin : g_mc
      for (k = 0; k < `PTLB_N_PT; k++)
      begin : g_msk
        localparam int W = (g * `PTLB_N_PT + k) * 4;
        assign tmask[g][k] = {s.tm[W + 1][19:0], s.tm[W]};
        assign cmask[g][k] = {s.tm[W + 3][19:0], s.tm[W + 2]};
      end
      for (k = 1; k <= `PTLB_MAXSET; k++)
      begin : g_bor
        if ((g % `PTLB_CHAIN) >= k)
        begin : g_on
          assign bset[g][k - 1] = (s.mc[g][`PTLB_F_BOR +: 2] >= 2'(k)) & lend[g - k];
        end
        else
        begin : g_off
          assign bset[g][k - 1] = 1'b0;
        end
      end
      assign bor[g] = |bset[g];
      ptlb_macrocell u_mc (
        .pclk         (pclk),
        .presetn      (presetn),
        .run          (s.run),
        .cfg          (s.mc[g]),
        .lit          (lit),
        .tmask        (tmask[g]),
        .cmask        (cmask[g]),
        .gnet         (gnet),
        .gclr_n       (global_clear_pin_low),
        .fast_pin     (io_in[g]),
        .fast_pin_dly (s.io_d[`PTLB_DLY_CYC - 1][g]),
        .borrow_in    (bor[g]),
        .q_out        (q[g]),
        .shr_out      (shr[g]),
        .lend_out     (lend[g])
      );
    end
  endgenerate

  //--------------------------------------------------------------------
  // register read data
  //--------------------------------------------------------------------
  assign rg = ptlb_region(paddr);
  always_comb
  begin
    idx   = 9'h000;
    rdata = 32'h0000_0000;
    unique case (rg)
      ptlb_pkg::PTLB_RG_CTRL: rdata = {31'h0000_0000, s.run};
      ptlb_pkg::PTLB_RG_STAT: rdata = {s.io_d[0], s.fb};
      ptlb_pkg::PTLB_RG_CLK:  rdata = {28'h000_0000, s.clk};
      ptlb_pkg::PTLB_RG_OE:
      begin
        idx   = ptlb_index(paddr, `PTLB_A_OE);
        rdata = {26'h000_0000, s.oe[idx[2:0]]};
      end
      ptlb_pkg::PTLB_RG_MC:
      begin
        idx   = ptlb_index(paddr, `PTLB_A_MC);
        rdata = s.mc[idx[3:0]];
      end
      ptlb_pkg::PTLB_RG_RT:
      begin
        idx   = ptlb_index(paddr, `PTLB_A_RT);
        rdata = {25'h000_0000, s.rt[idx[5:0]]};
      end
      ptlb_pkg::PTLB_RG_TM:
      begin
        idx   = ptlb_index(paddr, `PTLB_A_TM);
        rdata = s.tm[idx];
      end
      default: rdata = 32'h0000_0000;
    endcase
  end

  //--------------------------------------------------------------------
  // next state: apb slave and pin drivers
  //--------------------------------------------------------------------
  always_comb
  begin
    n   = s;
    oes = 4'h0;
    // one wait state, write lands on the edge that ends the access
    unique case (s.apb)
      ptlb_pkg::PTLB_IDLE:
      begin
        if (psel && penable)
        begin
          n.apb     = ptlb_pkg::PTLB_ACK;
          n.pready  = 1'b1;
          n.pslverr = (rg == ptlb_pkg::PTLB_RG_NONE);
          n.prdata  = rdata;
        end
      end
      ptlb_pkg::PTLB_ACK:
      begin
        n.apb     = ptlb_pkg::PTLB_IDLE;
        n.pready  = 1'b0;
        n.pslverr = 1'b0;
        if (pwrite)
        begin
          unique case (rg)
            ptlb_pkg::PTLB_RG_CTRL: n.run = pwdata[0];
            ptlb_pkg::PTLB_RG_CLK:  n.clk = pwdata[3:0];
            ptlb_pkg::PTLB_RG_OE:   n.oe[idx[2:0]] = pwdata[5:0];
            ptlb_pkg::PTLB_RG_MC:   n.mc[idx[3:0]] = pwdata;
            ptlb_pkg::PTLB_RG_RT:   n.rt[idx[5:0]] = pwdata[6:0];
            ptlb_pkg::PTLB_RG_TM:   n.tm[idx] = pwdata;
            default:                n.run = s.run;
          endcase
        end
      end
      default: n.apb = ptlb_pkg::PTLB_IDLE;
    endcase
    // feedback, shareable terms and pin delay line
    n.fb      = q;
    n.shr     = shr;
    n.io_d[0] = io_in;
    for (int i = 1; i < `PTLB_DLY_CYC; i++)
      n.io_d[i] = s.io_d[i - 1];
    // pin drivers: tied low, tied high or a global enable
    n.io_out = q;
    for (int i = 0; i < `PTLB_N_MC; i++)
    begin
      oes = s.mc[i][`PTLB_F_OES +: 4];
      if (oes == 4'h0)
        n.io_oe[i] = 1'b0;
      else if (oes == 4'h1)
        n.io_oe[i] = 1'b1;
      else if (oes < 4'h8)
        n.io_oe[i] = oenet[3'(oes - 4'h2)];
      else
        n.io_oe[i] = 1'b0;
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= '0;
    else
      s <= n;
  end

  // outputs straight from flops
  assign prdata  = s.prdata;
  assign pready  = s.pready;
  assign pslverr = s.pslverr;
  assign io_out  = s.io_out;
  assign io_oe   = s.io_oe;

  //--------------------------------------------------------------------
  // checks
  //--------------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_apb_ack;
    psel && penable && !pready |=> pready ##1 !pready;
  endproperty
  a_apb_ack: assert property (p_apb_ack) else $error("apb answer not one cycle");
  property p_oe_low;
    s.mc[0][`PTLB_F_OES +: 4] == 4'h0 |=> !io_oe[0];
  endproperty
  a_oe_low: assert property (p_oe_low) else $error("tied-low pin driven");
  property p_oe_high;
    s.mc[0][`PTLB_F_OES +: 4] == 4'h1 |=> io_oe[0];
  endproperty
  a_oe_high: assert property (p_oe_high) else $error("tied-high pin not driven");
  property p_oe_net;
    s.mc[3][`PTLB_F_OES +: 4] == 4'h2 |=> io_oe[3] == $past(oenet[0]);
  endproperty
  a_oe_net: assert property (p_oe_net) else $error("pin enable not from net");
  // pready stands one cycle, then drops
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("pready held too long");
  // refused address answers with error and zero data
  property p_slverr;
    psel && penable && !pready && rg == ptlb_pkg::PTLB_RG_NONE
      |=> pready && pslverr && prdata == 32'h0000_0000;
  endproperty
  a_slverr: assert property (p_slverr) else $error("refused access not flagged");
  // run bit follows a control write
  property p_run_write;
    psel && penable && pready && pwrite && !pslverr && paddr == `PTLB_A_CTRL
      |=> s.run == $past(pwdata[0]);
  endproperty
  a_run_write: assert property (p_run_write) else $error("run bit not written");
  // cleared enable bit blocks the routed source
  property p_route_off;
    !s.rt[0][`PTLB_RT_EN] |-> !gin[0];
  endproperty
  a_route_off: assert property (p_route_off) else $error("disabled route passed");
  // net one inverted, net zero true, both from pin one
  property p_net_sel;
    s.clk == 4'h8 |-> gnet[1] == !global_clock_pin_one && gnet[0] == global_clock_pin_one;
  endproperty
  a_net_sel: assert property (p_net_sel) else $error("clock net selection wrong");
  // one borrowed set takes the lower neighbour
  property p_borrow;
    s.mc[4][`PTLB_F_BOR +: 2] == 2'h1 |-> bor[4] == lend[3];
  endproperty
  a_borrow: assert property (p_borrow) else $error("borrowed set missing");
  property p_route;
    s.rt[0][`PTLB_RT_EN] && s.rt[0][5:0] == 6'h05 |-> gin[0] == io_in[0];
  endproperty
  a_route: assert property (p_route) else $error("routed input wrong");
  property p_chain;
    s.run |-> !bor[0] && !bor[`PTLB_CHAIN];
  endproperty
  a_chain: assert property (p_chain) else $error("chain bottom borrowed");
  c_apb_wr: cover property (psel && penable && pready && pwrite);
  c_pin_drive: cover property (io_oe[0] && io_out[0]);
  c_oe_net: cover property (io_oe[3]);
  c_borrow: cover property (s.run && bor[4]);
endmodule : ptlb_logic_group

// [src/ptlb_regs.svh]
// register map, field positions and timing counts of the logic fabric
`ifndef PTLB_REGS_SVH
`define PTLB_REGS_SVH
`define PTLB_A_CTRL 12'h000
`define PTLB_A_STAT 12'h004
`define PTLB_A_CLK  12'h008
`define PTLB_A_OE   12'h010
`define PTLB_A_MC   12'h040
`define PTLB_A_RT   12'h100
`define PTLB_A_TM   12'h400
`define PTLB_N_MC   16
`define PTLB_N_GIN  36
`define PTLB_N_LIT  52
`define PTLB_N_PT   5
`define PTLB_N_OE   6
`define PTLB_N_TW   320
`define PTLB_N_SRC  37
`define PTLB_CHAIN  8
`define PTLB_MAXSET 3
`define PTLB_F_OR   0
`define PTLB_F_LEND 5
`define PTLB_F_BOR  10
`define PTLB_F_XINV 12
`define PTLB_F_TYPE 13
`define PTLB_F_CKM  16
`define PTLB_F_NET  18
`define PTLB_F_GCLR 19
`define PTLB_F_PWR  20
`define PTLB_F_FAST 21
`define PTLB_F_FDLY 22
`define PTLB_F_OES  23
`define PTLB_RT_EN  6
`define PTLB_CLK_PS 100000
`define PTLB_FAST_SU_PS 1000
`define PTLB_DLY_CYC ((`PTLB_FAST_SU_PS + `PTLB_CLK_PS - 1) / `PTLB_CLK_PS)
`endif

// [src/ptlb_pkg.sv]
// types shared by the logic fabric modules
package ptlb_pkg;
`include "ptlb_regs.svh"
  typedef enum logic [2:0] {PTLB_BYP = 3'h0, PTLB_D = 3'h1, PTLB_T = 3'h2,
                            PTLB_JK = 3'h3, PTLB_SR = 3'h4} ptlb_ff_t;
  typedef enum logic [1:0] {PTLB_GCK = 2'h0, PTLB_GCE = 2'h1, PTLB_ACK_CK = 2'h2} ptlb_ckm_t;
  typedef enum logic {PTLB_IDLE = 1'b0, PTLB_ACK = 1'b1} ptlb_apb_t;
  typedef enum logic [2:0] {PTLB_RG_NONE = 3'h0, PTLB_RG_CTRL = 3'h1, PTLB_RG_STAT = 3'h2,
                            PTLB_RG_CLK = 3'h3, PTLB_RG_OE = 3'h4, PTLB_RG_MC = 3'h5,
                            PTLB_RG_RT = 3'h6, PTLB_RG_TM = 3'h7} ptlb_rg_t;
  typedef struct packed {
    logic q;
    logic ck_prev;
    logic net_prev;
  } ptlb_mc_st_t;
  typedef struct packed {
    ptlb_apb_t                               apb;
    logic                                    pready;
    logic                                    pslverr;
    logic [31:0]                             prdata;
    logic                                    run;
    logic [3:0]                              clk;
    logic [`PTLB_N_OE-1:0][5:0]              oe;
    logic [`PTLB_N_MC-1:0][31:0]             mc;
    logic [`PTLB_N_GIN-1:0][6:0]             rt;
    logic [`PTLB_N_TW-1:0][31:0]             tm;
    logic [`PTLB_N_MC-1:0]                   fb;
    logic [`PTLB_N_MC-1:0]                   shr;
    logic [`PTLB_DLY_CYC-1:0][`PTLB_N_MC-1:0] io_d;
    logic [`PTLB_N_MC-1:0]                   io_out;
    logic [`PTLB_N_MC-1:0]                   io_oe;
  } ptlb_top_st_t;
endpackage : ptlb_pkg

// [src/ptlb_macrocell.sv]
// one macrocell: five product terms, select matrix and programmable register
`timescale 1ns/100ps
`include "ptlb_regs.svh"
module ptlb_macrocell (
  input  wire logic                                      pclk,
  input  wire logic                                      presetn,
  input  wire logic                                      run,
  input  wire logic [31:0]                               cfg,
  input  wire logic [`PTLB_N_LIT-1:0]                    lit,
  input  wire logic [`PTLB_N_PT-1:0][`PTLB_N_LIT-1:0]    tmask,
  input  wire logic [`PTLB_N_PT-1:0][`PTLB_N_LIT-1:0]    cmask,
  input  wire logic [1:0]                                gnet,
  input  wire logic                                      gclr_n,
  input  wire logic                                      fast_pin,
  input  wire logic                                      fast_pin_dly,
  input  wire logic                                      borrow_in,
  output logic                                           q_out,
  output logic                                           shr_out,
  output logic                                           lend_out
);
  // and of selected literals; a term with no literal selected stays low
  function automatic logic ptlb_pterm(input logic [`PTLB_N_LIT-1:0] l,
                                      input logic [`PTLB_N_LIT-1:0] tm,
                                      input logic [`PTLB_N_LIT-1:0] cm);
    ptlb_pterm = (|(tm | cm)) & (&(l | ~tm)) & (&(~l | ~cm));
  endfunction : ptlb_pterm

  ptlb_pkg::ptlb_mc_st_t s, n;
  logic [`PTLB_N_PT-1:0] t, ctl, or_use;
  logic                  sum, d, net, ev, clr, pre;
  ptlb_pkg::ptlb_ff_t    ftype;
  ptlb_pkg::ptlb_ckm_t   ckm;

  // logic array, one product term per index
  genvar g;
  generate
    for (g = 0; g < `PTLB_N_PT; g++)
    begin : g_pt
      assign t[g] = ptlb_pterm(lit, tmask[g], cmask[g]);
    end
  endgenerate

  // select matrix: terms not on the or gate become controls
  assign or_use   = cfg[`PTLB_F_OR +: `PTLB_N_PT];
  assign ctl      = t & ~or_use;
  assign shr_out  = ~ctl[0];
  assign lend_out = |(t & cfg[`PTLB_F_LEND +: `PTLB_N_PT]);
  assign ftype    = ptlb_pkg::ptlb_ff_t'(cfg[`PTLB_F_TYPE +: 3]);
  assign ckm      = ptlb_pkg::ptlb_ckm_t'(cfg[`PTLB_F_CKM +: 2]);
  assign q_out    = (ftype == ptlb_pkg::PTLB_BYP) ? sum : s.q;

  // or/xor path, clock choice, async controls, next register value
  always_comb
  begin
    n   = s;
    sum = ((|(t & or_use)) | borrow_in) ^ cfg[`PTLB_F_XINV];
    d   = cfg[`PTLB_F_FAST] ? (cfg[`PTLB_F_FDLY] ? fast_pin_dly : fast_pin) : sum;
    net = gnet[cfg[`PTLB_F_NET]];
    unique case (ckm)
      ptlb_pkg::PTLB_GCK:    ev = net & ~s.net_prev;
      ptlb_pkg::PTLB_GCE:    ev = net & ~s.net_prev & ctl[1];
      ptlb_pkg::PTLB_ACK_CK: ev = ctl[1] & ~s.ck_prev;
      default:               ev = 1'b0;
    endcase
    clr = cfg[`PTLB_F_GCLR] ? ~gclr_n : ctl[2];
    pre = ctl[3];
    n.net_prev = net;
    n.ck_prev  = ctl[1];
    if (!run)
      n.q = cfg[`PTLB_F_PWR];
    else if (clr)
      n.q = 1'b0;
    else if (pre)
      n.q = 1'b1;
    else if (ev)
    begin
      unique case (ftype)
        ptlb_pkg::PTLB_D:  n.q = d;
        ptlb_pkg::PTLB_T:  n.q = s.q ^ d;
        ptlb_pkg::PTLB_JK: n.q = (d & ~s.q) | (~ctl[4] & s.q);
        ptlb_pkg::PTLB_SR: n.q = d | (~ctl[4] & s.q);
        default:           n.q = s.q;
      endcase
    end
  end

  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= '0;
    else
      s <= n;
  end

  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_clear;
    run && clr |=> !s.q;
  endproperty
  a_clear: assert property (p_clear) else $error("clear did not force low");
  property p_gclr;
    run && cfg[`PTLB_F_GCLR] && !gclr_n |=> !s.q;
  endproperty
  a_gclr: assert property (p_gclr) else $error("global clear ignored");
  property p_preset;
    run && pre && !clr |=> s.q;
  endproperty
  a_preset: assert property (p_preset) else $error("preset did not force high");
  property p_pwr;
    !run |=> s.q == $past(cfg[`PTLB_F_PWR]);
  endproperty
  a_pwr: assert property (p_pwr) else $error("power-up value wrong");
  property p_dff;
    run && ftype == ptlb_pkg::PTLB_D && ev && !clr && !pre |=> s.q == $past(d);
  endproperty
  a_dff: assert property (p_dff) else $error("d register missed data");
  property p_ce_hold;
    run && ckm == ptlb_pkg::PTLB_GCE && !ctl[1] && !clr && !pre |=> $stable(s.q);
  endproperty
  a_ce_hold: assert property (p_ce_hold) else $error("disabled register changed");
  c_jk: cover property (run && ftype == ptlb_pkg::PTLB_JK && ev);
endmodule : ptlb_macrocell

// [verif/tb.sv]
// self-checking bench for the logic block group over apb and pins
`timescale 1ns/100ps
module tb;
  logic        pclk     = 1'b0;
  logic        presetn  = 1'b0;
  logic [11:0] paddr    = 12'h000;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [31:0] pwdata   = 32'h0000_0000;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        ck_one   = 1'b0;
  logic        clr_low  = 1'b1;
  logic        oe_one   = 1'b0;
  logic [15:0] io_in    = 16'h0000;
  logic [15:0] io_out;
  logic [15:0] io_oe;
  logic [31:0] rd;
  logic        er;
  int          err_count = 0;
  int          n_checks  = 0;
  // routing, terms, clock nets and macrocell setup as address and data pairs
  localparam logic [43:0] CFG [21] = '{
    44'h100_00000045, 44'h104_00000046, 44'h008_00000008, 44'h400_00000001,
    44'h450_00000001, 44'h4A0_00000002, 44'h4F0_00000002, 44'h630_00000002,
    44'h5E0_00000001, 44'h6D4_00000400, 44'h720_00000001, 44'h730_00000002,
    44'h040_00800001, 44'h044_00802001, 44'h048_001C2001, 44'h04C_01000020,
    44'h050_00800400, 44'h05C_00000020, 44'h060_00800400, 44'h064_00800001,
    44'h068_00014001};

  ptlb_logic_group ptlb_logic_group_i (
    .pclk                 (pclk),
    .presetn              (presetn),
    .paddr                (paddr),
    .psel                 (psel),
    .penable              (penable),
    .pwrite               (pwrite),
    .pwdata               (pwdata),
    .prdata               (prdata),
    .pready               (pready),
    .pslverr              (pslverr),
    .global_clock_pin_one (ck_one),
    .global_clock_pin_two (1'b0),
    .global_clear_pin_low (clr_low),
    .oe_pin_one           (oe_one),
    .oe_pin_two           (1'b0),
    .io_in                (io_in),
    .io_out               (io_out),
    .io_oe                (io_oe)
  );

  // clock of 100 ns period
  always #50 pclk = ~pclk;

  // one apb transfer, held until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // compare seen against expected
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // let routed, registered and feedback paths settle
  task automatic settle;
    repeat (6) @(posedge pclk);
  endtask : settle

  // verdict and end of run
  task automatic end_sim;
    if (err_count == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim

  // watchdog against a hang
  initial
  begin
    #2000000;
    err_count++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_sim();
  end

  // main sequence
  initial
  begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({io_out, io_oe}, 32'h0000_0000);
    apb(1'b0, 12'h000, 32'h0);
    chk({31'h0, er}, 32'h0);
    chk(rd, 32'h0000_0000);
    apb(1'b0, 12'h00C, 32'h0);
    chk({rd[30:0], er}, 32'h1);
    apb(1'b1, 12'h002, 32'h1);
    chk({31'h0, er}, 32'h1);
    foreach (CFG[i])
    begin
      apb(1'b1, CFG[i][43:32], CFG[i][31:0]);
      chk({31'h0, er}, 32'h0);
    end
    apb(1'b0, 12'h048, 32'h0);
    chk(rd, 32'h001C_2001);
    settle();
    apb(1'b0, 12'h004, 32'h0);
    chk(rd & 32'h4, 32'h4);
    apb(1'b1, 12'h000, 32'h1);
    settle();
    chk({16'h0, io_oe}, 32'h0313);
    chk({16'h0, io_out & 16'h0313}, 32'h0200);
    io_in <= 16'h0003;
    settle();
    chk({16'h0, io_out & 16'h0313}, 32'h0011);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd & 32'hFFFF_0004, 32'h0003_0004);
    io_in <= 16'h0001;
    settle();
    ck_one <= 1'b1;
    settle();
    chk({16'h0, io_out & 16'h0313}, 32'h0003);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd & 32'h4, 32'h4);
    chk(rd & 32'h400, 32'h0);
    ck_one <= 1'b0;
    settle();
    apb(1'b0, 12'h004, 32'h0);
    chk(rd & 32'h4, 32'h0);
    io_in <= 16'h0003;
    ck_one <= 1'b1;
    settle();
    ck_one <= 1'b0;
    settle();
    apb(1'b0, 12'h004, 32'h0);
    chk(rd & 32'h4, 32'h4);
    chk(rd & 32'h400, 32'h400);
    clr_low <= 1'b0;
    settle();
    apb(1'b0, 12'h004, 32'h0);
    chk(rd & 32'h4, 32'h0);
    clr_low <= 1'b1;
    io_in <= 16'h0000;
    settle();
    chk({16'h0, io_out & 16'h0313}, 32'h0202);
    oe_one <= 1'b1;
    settle();
    chk({16'h0, io_oe}, 32'h031B);
    apb(1'b1, 12'h000, 32'h0);
    settle();
    apb(1'b0, 12'h004, 32'h0);
    chk(rd & 32'h6, 32'h4);
    end_sim();
  end
endmodule : tb
